// [src/ser_params.svh]
`ifndef SER_PARAMS_SVH
`define SER_PARAMS_SVH

`define SER_W            16
`define SER_GROUPS       3
`define SER_SETTLE_BIT   1
`define SER_TRIG_BIT     5
`define SER_ARM_BIT      6
`define SER_IDLE_BIT     10
`define SER_LAYER_BIT    1
`define SER_OPER_MASK    16'h0462
`define SER_TRIG_MASK    16'h0002
`define SER_ARM_MASK     16'h0002
`define SER_EVT_RESET    16'h0000
`define SER_FALL_PRESET  16'h0000
`define SER_QUEUE_DEPTH  16
`define SER_CODE_W       5
`define SER_ADMIT_RESET  32'hFFFFFFFF
`define SER_RESP_W       32

`endif

// [src/ser_pkg.sv]
`include "ser_params.svh"
package ser_pkg;

  typedef enum logic [1:0] {
    SER_GRP_OPER,
    SER_GRP_TRIG,
    SER_GRP_ARM
  } ser_grp_e;

  typedef enum logic [3:0] {
    SER_CMD_EVENT_RD,
    SER_CMD_RISE_WR,
    SER_CMD_RISE_RD,
    SER_CMD_FALL_WR,
    SER_CMD_FALL_RD,
    SER_CMD_COND_RD,
    SER_CMD_PRESET,
    SER_CMD_CLEAR,
    SER_CMD_QUEUE_RD,
    SER_CMD_ADMIT_WR,
    SER_CMD_ADMIT_RD,
    SER_CMD_EXCL_WR,
    SER_CMD_EXCL_RD
  } ser_op_e;

  typedef struct packed {
    ser_op_e                 op;
    ser_grp_e                grp;
    logic [`SER_RESP_W-1:0]  data;
  } ser_cmd_s;

  typedef struct packed {
    logic settling;
    logic wait_trigger;
    logic wait_arm;
    logic idle;
    logic layer_presence_flag_trig;
    logic layer_presence_flag_arm;
  } ser_cond_s;

endpackage

// [src/ser_msg_mem.sv]
`timescale 1ns/1ns
module ser_msg_mem #(
  parameter int W = 5,
  parameter int D = 16,
  parameter int A = $clog2(D)
) (
  // clock
  input  wire logic         clk,
  // write port
  input  wire logic         we,
  input  wire logic [A-1:0] waddr,
  input  wire logic [W-1:0] wdata,
  // read port, data registered
  input  wire logic [A-1:0] raddr,
  output logic      [W-1:0] rdata
);

  logic [W-1:0] mem [D];

  // read-before-write: a same-cycle replace still returns the old word
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end

endmodule

// [src/ser_status_bank.sv]
`timescale 1ns/1ns
`include "ser_params.svh"
// Functional notes
// - event query returns register value as binary
// - rising filter sets event on 0 to 1
// - falling filter sets event on 1 to 0
// - operation bit 1 tracks relay settling
// - operation bit 5 tracks trigger layer wait
// - operation bit 6 tracks arm layer wait
// - operation bit 10 tracks idle state
// - unused operation bits never set
// - trigger register uses only bit 1
// - arm register uses only bit 1
// - filters writable/readable, condition readable per group
// - preset returns filters to defaults
// - queue query returns most recent message
// - admit and exclude lists, both queryable
module ser_status_bank #(
  parameter int QDEPTH = `SER_QUEUE_DEPTH,
  parameter int CODE_W = `SER_CODE_W
) (
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  // live conditions from the sequencer, same clock
  input  wire ser_pkg::ser_cond_s     cond,
  // error and status message source
  input  wire logic                   msg_valid,
  input  wire logic [CODE_W-1:0]      msg_code,
  // decoded host commands
  input  wire logic                   cmd_valid,
  input  wire ser_pkg::ser_cmd_s      cmd,
  // query answers
  output logic                        resp_valid,
  output logic [`SER_RESP_W-1:0]      resp_data,
  // queue state
  output logic                        queue_empty
);
  import ser_pkg::*;

  localparam int NG    = `SER_GROUPS;
  localparam int W     = `SER_W;
  localparam int NCODE = 1 << CODE_W;
  localparam int QA    = $clog2(QDEPTH);
  localparam int RW    = `SER_RESP_W;
  // defined bits per group, every other position stays zero
  localparam logic [W-1:0] GMASK [NG] =
    '{`SER_OPER_MASK, `SER_TRIG_MASK, `SER_ARM_MASK};

  // per-group event, filter and last-sample registers
  logic [W-1:0]     evt   [NG];
  logic [W-1:0]     rise  [NG];
  logic [W-1:0]     fall  [NG];
  logic [W-1:0]     prev  [NG];
  wire  [W-1:0]     cvec  [NG];
  // admit map, stack fill count and answer registers
  logic [NCODE-1:0] admit;
  logic [QA:0]      qcnt;
  logic             resp_q;
  logic [`SER_RESP_W-1:0] resp_reg;
  wire  [CODE_W-1:0] mem_rdata;

  // condition vectors, only the documented positions are wired
  assign cvec[0] = (W'(cond.settling)     << `SER_SETTLE_BIT)
                 | (W'(cond.wait_trigger) << `SER_TRIG_BIT)
                 | (W'(cond.wait_arm)     << `SER_ARM_BIT)
                 | (W'(cond.idle)         << `SER_IDLE_BIT);
  assign cvec[1] = W'(cond.layer_presence_flag_trig)
                   << `SER_LAYER_BIT;
  assign cvec[2] = W'(cond.layer_presence_flag_arm)
                   << `SER_LAYER_BIT;

  // command decode
  wire op_evt_rd  = cmd_valid && cmd.op == SER_CMD_EVENT_RD;
  wire op_rise_wr = cmd_valid && cmd.op == SER_CMD_RISE_WR;
  wire op_rise_rd = cmd_valid && cmd.op == SER_CMD_RISE_RD;
  wire op_fall_wr = cmd_valid && cmd.op == SER_CMD_FALL_WR;
  wire op_fall_rd = cmd_valid && cmd.op == SER_CMD_FALL_RD;
  wire op_cond_rd = cmd_valid && cmd.op == SER_CMD_COND_RD;
  wire op_preset  = cmd_valid && cmd.op == SER_CMD_PRESET;
  wire op_clear   = cmd_valid && cmd.op == SER_CMD_CLEAR;
  wire op_q_rd    = cmd_valid && cmd.op == SER_CMD_QUEUE_RD;
  wire op_adm_wr  = cmd_valid && cmd.op == SER_CMD_ADMIT_WR;
  wire op_adm_rd  = cmd_valid && cmd.op == SER_CMD_ADMIT_RD;
  wire op_exc_wr  = cmd_valid && cmd.op == SER_CMD_EXCL_WR;
  wire op_exc_rd  = cmd_valid && cmd.op == SER_CMD_EXCL_RD;

  // writes, preset and clear never answer
  wire is_query   = op_evt_rd || op_rise_rd || op_fall_rd || op_cond_rd
                  || op_q_rd || op_adm_rd || op_exc_rd;
  // group 3 does not exist: it reads zero and writes nothing
  wire grp_ok     = cmd.grp != 2'h3;
  wire [1:0] gi   = grp_ok ? cmd.grp : 2'h0;

  // one slice per event group, all groups share the same filter logic
  genvar g;
  generate
    for (g = 0; g < NG; g++) begin : gen_grp
      wire sel = cmd.grp == 2'(g);
      // masking with the group's defined bits keeps unused ones clear
      wire [W-1:0] hit = ((cvec[g] & ~prev[g] & rise[g])
                        | (~cvec[g] & prev[g] & fall[g]))
                        & GMASK[g];
      // a new edge beats a clear or a read in the same cycle
      wire [W-1:0] next_evt = (op_clear || (op_evt_rd && sel))
                            ? hit : (evt[g] | hit);
      // preset wins over a filter write in the same cycle
      wire [W-1:0] next_rise = op_preset ? GMASK[g]
                             : (op_rise_wr && sel)
                             ? cmd.data[W-1:0] & GMASK[g]
                             : rise[g];
      wire [W-1:0] next_fall = op_preset ? `SER_FALL_PRESET
                             : (op_fall_wr && sel)
                             ? cmd.data[W-1:0] & GMASK[g]
                             : fall[g];

      // prev starts low, so a condition high at release reads as a rise
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          evt[g]  <= `SER_EVT_RESET;
          prev[g] <= '0;
        end else begin
          evt[g]  <= next_evt;
          prev[g] <= cvec[g];
        end
      end

      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          rise[g] <= GMASK[g];
          fall[g] <= `SER_FALL_PRESET;
        end else begin
          rise[g] <= next_rise;
          fall[g] <= next_fall;
        end
      end
    end
  endgenerate

  // message queue kept as a stack so the newest entry answers first
  // qcnt counts entries, so the top word sits at qcnt - 1
  wire q_full   = qcnt == (QA + 1)'(QDEPTH);
  wire q_nonempty = qcnt != '0;
  wire pop      = op_q_rd && q_nonempty;
  // a code outside the admit map never reaches the stack
  wire admitted = msg_valid && admit[msg_code];
  // when full, a newcomer is dropped unless a pop frees the top
  wire push     = admitted && !op_clear && (!q_full || pop);
  wire [QA-1:0] top_addr = QA'(qcnt - 1'b1);
  wire [QA-1:0] wr_addr  = pop ? top_addr : QA'(qcnt);
  wire [QA:0] next_qcnt  = op_clear ? '0
                         : (push && !pop) ? qcnt + 1'b1
                         : (pop && !push) ? qcnt - 1'b1 : qcnt;

  // the stack words live in a small memory with a registered read
  ser_msg_mem #(
    .W (CODE_W),
    .D (QDEPTH)
  ) u_mem (
    .clk   (clk),
    .we    (push),
    .waddr (wr_addr),
    .wdata (msg_code),
    .raddr (top_addr),
    .rdata (mem_rdata)
  );

  // query answer select, 16-bit registers sit in the low half
  wire [W-1:0]  grp_evt   = grp_ok ? evt[gi]  : '0;
  wire [W-1:0]  grp_rise  = grp_ok ? rise[gi] : '0;
  wire [W-1:0]  grp_fall  = grp_ok ? fall[gi] : '0;
  wire [W-1:0]  grp_cond  = grp_ok ? cvec[gi] : '0;
  wire [RW-1:0] next_resp = op_evt_rd  ? RW'(grp_evt)
                          : op_rise_rd ? RW'(grp_rise)
                          : op_fall_rd ? RW'(grp_fall)
                          : op_cond_rd ? RW'(grp_cond)
                          : op_adm_rd  ? RW'(admit)
                          : op_exc_rd  ? RW'(~admit)
                          : '0;

  // ones in the admit map let a code in; the exclude list is its complement
  wire [NCODE-1:0] adm_set    = admit | cmd.data[NCODE-1:0];
  wire [NCODE-1:0] adm_clr    = admit & ~cmd.data[NCODE-1:0];
  wire [NCODE-1:0] next_admit = op_adm_wr ? adm_set
                              : op_exc_wr ? adm_clr : admit;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      qcnt <= '0;
    end else begin
      qcnt <= next_qcnt;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      admit <= `SER_ADMIT_RESET;
    end else begin
      admit <= next_admit;
    end
  end

  // answers appear one cycle after the query is taken
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      resp_valid <= 1'b0;
      resp_q     <= 1'b0;
      resp_reg   <= '0;
    end else begin
      resp_valid <= is_query;
      resp_q     <= pop;
      resp_reg   <= next_resp;
    end
  end

  // an empty queue answers zero, meaning no message; the stack word comes
  // straight from the memory register to keep the one-cycle answer
  assign resp_data   = resp_q ? 32'(mem_rdata) : resp_reg;
  assign queue_empty = !q_nonempty;

endmodule

// [verification/ser_status_chk.sv]
`timescale 1ns/1ns
module ser_status_chk #(
  parameter int QDEPTH = 16,
  parameter int CODE_W = 5
) (
  // clock and reset
  input wire logic               clk,
  input wire logic               rst_n,
  // block inputs
  input wire ser_pkg::ser_cond_s cond,
  input wire logic               msg_valid,
  input wire logic [CODE_W-1:0]  msg_code,
  input wire logic               cmd_valid,
  input wire ser_pkg::ser_cmd_s  cmd,
  // block outputs
  input wire logic               resp_valid,
  input wire logic [31:0]        resp_data,
  input wire logic               queue_empty
);
  import ser_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire q16 = cmd_valid && cmd.op inside {SER_CMD_EVENT_RD,
    SER_CMD_RISE_RD, SER_CMD_FALL_RD, SER_CMD_COND_RD};
  wire qry = q16 || cmd_valid && cmd.op inside {SER_CMD_QUEUE_RD,
    SER_CMD_ADMIT_RD, SER_CMD_EXCL_RD};
  wire evr = cmd_valid && cmd.op == SER_CMD_EVENT_RD;
  wire pop = cmd_valid && cmd.op == SER_CMD_QUEUE_RD;
  a_query_answered: assert property (qry |=> resp_valid)
    else $error("query not answered");
  a_write_silent: assert property (!qry |=> !resp_valid)
    else $error("answer without query");
  a_upper_half_zero: assert property (q16 |=> resp_data[31:16] == 16'h0)
    else $error("upper half set");
  a_oper_unused_zero: assert property (evr && cmd.grp == SER_GRP_OPER
    |=> (resp_data & ~32'h462) == 32'h0) else $error("unused bit set");
  a_layer_only_b1: assert property (evr && cmd.grp != SER_GRP_OPER
    |=> (resp_data & ~32'h2) == 32'h0) else $error("layer bit stray");
  a_bad_group_zero: assert property (q16 && cmd.grp == 2'h3
    |=> resp_data == 32'h0) else $error("bad group read");
  a_empty_pop_zero: assert property (pop && queue_empty && !msg_valid
    |=> resp_data == 32'h0) else $error("empty pop data");
  a_clear_empties: assert property (cmd_valid &&
    cmd.op == SER_CMD_CLEAR |=> queue_empty) else $error("clear kept queue");
endmodule

bind ser_status_bank ser_status_chk #(.QDEPTH(QDEPTH), .CODE_W(CODE_W))
  u_chk (.clk(clk), .rst_n(rst_n), .cond(cond), .msg_valid(msg_valid),
  .msg_code(msg_code), .cmd_valid(cmd_valid), .cmd(cmd),
  .resp_valid(resp_valid), .resp_data(resp_data), .queue_empty(queue_empty));

// [verification/ser_host_model.sv]
`timescale 1ns/1ns
module ser_host_model (
  // clock
  input  wire logic        clk,
  // decoded commands
  output logic             cmd_valid,
  output ser_pkg::ser_cmd_s cmd
);
  import ser_pkg::*;
  initial begin
    cmd_valid = 1'b0;
    cmd = '0;
  end
  // word and parameter travel in separate fields
  task automatic send(ser_op_e op, ser_grp_e g, logic [31:0] d);
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd = '{op, g, d};
    @(negedge clk);
    cmd_valid = 1'b0;
    // stale data would hide a late sample
    cmd.data = ~d;
  endtask
endmodule

// [verification/tb.sv]
`timescale 1ns/1ns
module tb;
  import ser_pkg::*;
  localparam ser_op_e  EV = SER_CMD_EVENT_RD;
  localparam ser_grp_e GO = SER_GRP_OPER;
  logic        clk, rst_n, msg_valid, cmd_valid, resp_valid, queue_empty;
  logic [4:0]  msg_code;
  logic [31:0] resp_data;
  ser_cond_s   cond;
  ser_cmd_s    cmd;
  int          n_mismatch, tests_run;
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin \
  n_mismatch++; $display("ERROR %0t: got %0h exp %0h", $time, g, e); end end

  ser_status_bank uut (.clk(clk), .rst_n(rst_n), .cond(cond),
    .msg_valid(msg_valid), .msg_code(msg_code), .cmd_valid(cmd_valid),
    .cmd(cmd), .resp_valid(resp_valid), .resp_data(resp_data),
    .queue_empty(queue_empty));
  ser_host_model h (.clk(clk), .cmd_valid(cmd_valid), .cmd(cmd));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic q(ser_op_e op, ser_grp_e g, logic [31:0] e);
    h.send(op, g, 32'h0);
    `CHK(resp_valid, 1'b1)
    `CHK(resp_data, e)
  endtask

  task automatic push(logic [4:0] c);
    @(negedge clk);
    msg_valid = 1'b1;
    msg_code = c;
    @(negedge clk);
    msg_valid = 1'b0;
    msg_code = ~c;
  endtask

  task automatic t_edges();
    `CHK(queue_empty, 1'b1)
    q(EV, GO, 32'h0);
    q(SER_CMD_RISE_RD, SER_GRP_TRIG, 32'h2);
    h.send(SER_CMD_FALL_WR, GO, 32'hFFFF);
    q(SER_CMD_FALL_RD, GO, 32'h462);
    h.send(SER_CMD_FALL_WR, SER_GRP_TRIG, 32'h2);
    @(negedge clk) cond = '1;
    q(SER_CMD_COND_RD, GO, 32'h462);
    q(EV, GO, 32'h462);
    q(EV, SER_GRP_ARM, 32'h2);
    q(EV, SER_GRP_TRIG, 32'h2);
    q(EV, GO, 32'h0);
    @(negedge clk) cond = '0;
    q(EV, GO, 32'h462);
    q(EV, SER_GRP_TRIG, 32'h2);
    q(EV, SER_GRP_ARM, 32'h0);
    $display("t_edges done");
  endtask

  task automatic t_preset();
    @(negedge clk) cond = '1;
    h.send(SER_CMD_CLEAR, GO, 32'h0);
    q(EV, GO, 32'h0);
    @(negedge clk) cond = '0;
    h.send(SER_CMD_RISE_WR, GO, 32'h0);
    h.send(SER_CMD_PRESET, GO, 32'h0);
    q(EV, GO, 32'h462);
    q(SER_CMD_RISE_RD, GO, 32'h462);
    q(SER_CMD_FALL_RD, GO, 32'h0);
    q(SER_CMD_RISE_RD, ser_grp_e'(2'h3), 32'h0);
    $display("t_preset done");
  endtask

  task automatic t_queue();
    push(5'h3);
    push(5'h7);
    q(SER_CMD_QUEUE_RD, GO, 32'h7);
    q(SER_CMD_QUEUE_RD, GO, 32'h3);
    q(SER_CMD_QUEUE_RD, GO, 32'h0);
    h.send(SER_CMD_EXCL_WR, GO, 32'h8);
    q(SER_CMD_EXCL_RD, GO, 32'h8);
    q(SER_CMD_ADMIT_RD, GO, 32'hFFFFFFF7);
    push(5'h3);
    `CHK(queue_empty, 1'b1)
    h.send(SER_CMD_ADMIT_WR, GO, 32'h8);
    push(5'h3);
    `CHK(queue_empty, 1'b0)
    $display("t_queue done");
  endtask

  task automatic t_full();
    push(5'h3);
    h.send(SER_CMD_CLEAR, GO, 32'h0);
    `CHK(queue_empty, 1'b1)
    for (int i = 0; i < 17; i++) begin
      push(5'(i));
    end
    `CHK(queue_empty, 1'b0)
    q(SER_CMD_QUEUE_RD, GO, 32'hF);
    $display("t_full done");
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial begin
    rst_n = 1'b0;
    cond = '0;
    msg_valid = 1'b0;
    msg_code = 5'h0;
    n_mismatch = 0;
    tests_run = 0;
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    t_edges();
    t_preset();
    t_queue();
    t_full();
    end_sim();
  end
endmodule
